// File: single_vector_interrupt_sequencer_tb_top.sv
// Self-checking bench: APB register traffic, source pulses, entry/return.
// Assumes svis_pkg, svis_mem_if, svis_top and svis_core_model are compiled.
`timescale 1ns/1ps
`default_nettype none
module single_vector_interrupt_sequencer_tb_top;
  ////////////////////////////////////////////////////////////////////////
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        pwm_ovf, t0_match, irq_ack, irq_busy, pc_load_vld, irq, clk_en;
  logic [1:0]  port_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [15:0] pc_now, handler_addr, pc_load, last_pc;
  logic [7:0]  flags_now, flags_load, last_fl;
  int          n_mismatch, n_checks, n_ack, n_load;
  localparam logic [15:0] HND   = 16'h0400;
  // Per source: enable register, enable value, pending register, mask
  localparam logic [7:0]  ENI[4] = '{8'hF3, 8'hD2, 8'hE7, 8'hE7};
  localparam logic [7:0]  ENV[4] = '{8'h08, 8'h02, 8'h01, 8'h04};
  localparam logic [7:0]  PDI[4] = '{8'hF3, 8'hD2, 8'hE8, 8'hE8};
  localparam logic [7:0]  PDM[4] = '{8'h04, 8'h01, 8'h01, 8'h02};

  svis_top dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pwm_ovf, .t0_match,
    .port_pin, .pc_now, .flags_now, .handler_addr, .irq_ack, .irq_busy,
    .pc_load, .pc_load_vld, .flags_load, .irq);
  svis_core_model #(.HANDLER(HND)) core (.pclk, .presetn, .pc_load,
    .pc_load_vld, .pc_now, .flags_now, .handler_addr);

  ////////////////////////////////////////////////////////////////////////
  // Pulses counted mid-cycle so they never race the driving edge
  always @(negedge pclk) begin
    if (irq_ack === 1'b1) n_ack++;
    if (pc_load_vld === 1'b1) begin
      n_load++;
      last_pc = pc_load;
      last_fl = flags_load;
    end
  end

  task automatic check(input string s, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask : check

  // One APB transfer; an idle cycle after it avoids double assignment
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [31:0] d);
    int n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'h0, i, 2'h0};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) n_mismatch++;
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdc(input string s, input logic [7:0] i,
                     input logic [31:0] m, e);
    apb(1'b0, i, 32'h0);
    check(s, rv & m, e);
  endtask : rdc

  // Bounded wait for the next PC load pulse
  task automatic wait_load(input int l0);
    int n = 0;
    while (n_load == l0 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    check("load pulse", 32'(n_load - l0), 32'h1);
  endtask : wait_load

  task automatic pulse(input int i);
    case (i)
      0: pwm_ovf <= 1'b1;
      1: t0_match <= 1'b1;
      default: port_pin[i-2] <= 1'b1;
    endcase
    // Pins must outlast the filter that wants two agreeing stages
    repeat ((i > 1) ? 3 : 1) @(posedge pclk);
    pwm_ovf  <= 1'b0;
    t0_match <= 1'b0;
    port_pin <= 2'h0;
    repeat (6) @(posedge pclk); // Pin path needs its synchroniser
  endtask : pulse

  task automatic t_reset();
    rdc("mode reg", 8'hDF, 32'hFF, 32'h0);
    rdc("stack ptr", 8'hC5, 32'hFFFF, 32'h00FF);
    check("irq", irq, 1'b0);
    $display("test reset done");
  endtask : t_reset

  // Gated, accepted, entered, cleared and returned for one source
  task automatic t_source(input int i);
    int a0, l0;
    apb(1'b1, ENI[i], ENV[i]);
    pulse(i);
    rdc("pending", PDI[i], PDM[i], PDM[i]);
    apb(1'b1, 8'hC3, 32'h4); // Disable instruction
    a0 = n_ack;
    apb(1'b1, 8'hC3, 32'h1); // Boundary with global enable off
    repeat (8) @(posedge pclk);
    check("gated ack", 32'(n_ack - a0), 32'h0);
    apb(1'b1, 8'hC3, 32'h2);
    l0 = n_load;
    apb(1'b1, 8'hC3, 32'h1);
    apb(1'b1, 8'hC3, 32'h1); // Boundary again while entry runs
    check("busy", irq_busy, 1'b1);
    wait_load(l0);
    check("ack", 32'(n_ack - a0), 32'h1);
    check("handler", last_pc, HND);
    rdc("gie off", 8'hDF, 32'h8, 32'h0);
    rdc("still pending", PDI[i], PDM[i], PDM[i]);
    apb(1'b1, PDI[i], (PDI[i] == ENI[i]) ? ENV[i] : 8'h00);
    rdc("cleared", PDI[i], PDM[i], 32'h0);
    l0 = n_load;
    apb(1'b1, 8'hC3, 32'h8); // Return instruction
    wait_load(l0);
    check("pc back", last_pc, 16'h1234);
    check("flags back", last_fl, 8'hA5);
    rdc("gie on", 8'hDF, 32'h8, 32'h8);
    apb(1'b1, ENI[i], 32'h0);
    $display("test source %0d done", i);
  endtask : t_source

  task automatic t_status();
    rdc("status", 8'hC0, 32'hFF, 32'h07);
    check("irq masked", irq, 1'b0);
    apb(1'b1, 8'hC2, 32'h1);
    check("irq on", irq, 1'b1);
    // A write with the clock enable low must leave state untouched
    clk_en <= 1'b0;
    apb(1'b1, 8'hC2, 32'h7);
    clk_en <= 1'b1;
    rdc("frozen enable", 8'hC2, 32'hFF, 32'h1);
    apb(1'b1, 8'hC1, 32'h1);
    check("irq cleared", irq, 1'b0);
    rdc("status left", 8'hC0, 32'hFF, 32'h06);
    apb(1'b1, 8'h10, 32'hFF);
    check("err write", er, 1'b1);
    rdc("unmapped", 8'h10, 32'hFFFFFFFF, 32'h0);
    check("err read", er, 1'b1);
    $display("test status done");
  endtask : t_status

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////
  // Clock of 5 ns period
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Main sequence
  initial begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h0;
    pwdata   = 32'h0;
    pwm_ovf  = 1'b0;
    t0_match = 1'b0;
    port_pin = 2'h0;
    clk_en   = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    for (int i = 0; i < 4; i++) t_source(i);
    t_status();
    end_of_test();
  end

  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
endmodule : single_vector_interrupt_sequencer_tb_top
`default_nettype wire

// File: svis_core_model.sv
// Behavioural core beside the sequencer: supplies PC, flags and the
// vector word, and takes the branch or restore target on each load pulse.
// Assumes one clock and the active-low reset shared with the sequencer.
`timescale 1ns/1ps
`default_nettype none
module svis_core_model #(
  parameter logic [15:0] HANDLER  = 16'h0400,
  parameter logic [15:0] PC_START = 16'h1234,
  parameter logic [7:0]  FLAGS    = 8'hA5
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] pc_load,
  input  wire logic        pc_load_vld,
  output logic      [15:0] pc_now,
  output logic      [7:0]  flags_now,
  output logic      [15:0] handler_addr
);
  ////////////////////////////////////////////////////////////////////////
  // Vector bytes never change, so one word stands for both fetches
  assign flags_now    = FLAGS;
  assign handler_addr = HANDLER;
  // Program counter follows every load, so a return shows the saved PC
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pc_now <= PC_START;
    else if (pc_load_vld)
      pc_now <= pc_load;
  end
endmodule : svis_core_model
`default_nettype wire

// File: svis_mem_if.sv
// Memory bus between the sequencer and its stack and vector store.
// Assumes one byte access per cycle, answered combinationally.
`timescale 1ns/1ps
`default_nettype none
interface svis_mem_if;
  logic        wr;
  logic        rd;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  modport seq (output wr, output rd, output addr, output wdata,
               input rdata);
  modport mem (input wr, input rd, input addr, input wdata,
               output rdata);
endinterface : svis_mem_if
`default_nettype wire

// File: svis_pkg.sv
// Constants shared by the interrupt sequencer and its APB register slave.
// Assumes an 8-bit core register space mapped onto APB word addresses.
package svis_pkg;

  // Printed register addresses; not all multiples of four, so they are indices
  localparam logic [7:0] MODE_IDX     = 8'hDF; // system mode register
  localparam logic [7:0] PORT_CTL_IDX = 8'hE7; // port0 low control register
  localparam logic [7:0] PORT_PND_IDX = 8'hE8; // port0 pending register
  localparam logic [7:0] TMR_CTL_IDX  = 8'hD2; // timer0 control register
  localparam logic [7:0] PWM_CTL_IDX  = 8'hF3; // pulse width control register
  localparam logic [7:0] IRQ_STAT_IDX = 8'hC0; // sticky event status
  localparam logic [7:0] IRQ_CLR_IDX  = 8'hC1; // write-one clear of status
  localparam logic [7:0] IRQ_EN_IDX   = 8'hC2; // status interrupt enable
  localparam logic [7:0] SEQ_CTL_IDX  = 8'hC3; // core-side control strobes
  localparam logic [7:0] SEQ_STAT_IDX = 8'hC4; // sequencer state readback
  localparam logic [7:0] SEQ_SP_IDX   = 8'hC5; // stack pointer readback
  localparam logic [7:0] SEQ_PC_IDX   = 8'hC6; // last handler address

  // Field positions
  localparam int GIE_BIT     = 3; // global enable in system mode register
  localparam int T0_IE_BIT   = 1; // timer0 source enable
  localparam int T0_PND_BIT  = 0; // timer0 pending
  localparam int PWM_IE_BIT  = 3; // pwm overflow enable
  localparam int PWM_PND_BIT = 2; // pwm overflow pending
  localparam int P00_IE_BIT  = 0; // pin 0 enable in port control
  localparam int P01_IE_BIT  = 2; // pin 1 enable in port control
  localparam int NSRC        = 4; // number of sources

  // Source index in the pending vector
  localparam int SRC_PWM = 0;
  localparam int SRC_T0  = 1;
  localparam int SRC_P00 = 2;
  localparam int SRC_P01 = 3;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] REG_RST  = 8'h00;
  localparam logic [15:0] SP_RST  = 16'h00FF;
  localparam logic [15:0] PC_RST  = 16'h0100;

  // Vector bytes
  localparam logic [15:0] VEC_HI_ADDR = 16'h0000;
  localparam logic [15:0] VEC_LO_ADDR = 16'h0001;

  // Control strobe bits in the core-side control register
  localparam int CTL_EOI_BIT  = 0; // end of instruction boundary
  localparam int CTL_ION_BIT  = 1; // enable interrupt instruction
  localparam int CTL_IOFF_BIT = 2; // disable interrupt instruction
  localparam int CTL_RET_BIT  = 3; // interrupt return instruction

  // Status event bits
  localparam int EV_ACK_BIT   = 0; // request acknowledged
  localparam int EV_ENTRY_BIT = 1; // handler entered
  localparam int EV_RET_BIT   = 2; // return finished
  localparam int NEV          = 3;

  // Sequencer states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_PUSH_L = 9'h002,
    ST_PUSH_H = 9'h004,
    ST_PUSH_F = 9'h008,
    ST_VEC_H  = 9'h010,
    ST_VEC_L  = 9'h020,
    ST_POP_F  = 9'h040,
    ST_POP_H  = 9'h080,
    ST_POP_L  = 9'h100
  } svis_state_type;

endpackage : svis_pkg

// File: svis_stack_mem.sv
// Small byte store: stack area plus the two vector bytes.
// Assumes the sequencer issues at most one access per cycle.
`timescale 1ns/1ps
`default_nettype none
module svis_stack_mem (
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  clk_en,
  input  wire logic  [15:0] vec_addr,
  svis_mem_if.mem    mem
);
  logic [7:0] store_q [0:15];
  wire  [3:0] idx = mem.addr[3:0];

  // Vector bytes come from the configured handler address
  assign mem.rdata = !mem.rd ? 8'h00 :
                     (mem.addr == svis_pkg::VEC_HI_ADDR) ? vec_addr[15:8] :
                     (mem.addr == svis_pkg::VEC_LO_ADDR) ? vec_addr[7:0] :
                     store_q[idx];

  // Stack bytes written at the low four pointer bits; every address aliases into the store
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_byte
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          store_q[g] <= 8'h00;
        else if (clk_en && mem.wr && idx == 4'(g))
          store_q[g] <= mem.wdata;
      end
    end
  endgenerate
endmodule : svis_stack_mem
`default_nettype wire

// File: svis_top.sv
// Interrupt acceptance and entry/return sequencer with APB registers.
// Assumes core strobes arrive through the control register; sources are
// same-clock pulses except the two port pins, which are synchronised.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module svis_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pwm_ovf,
  input  wire logic        t0_match,
  input  wire logic [1:0]  port_pin,
  input  wire logic [15:0] pc_now,
  input  wire logic [7:0]  flags_now,
  input  wire logic [15:0] handler_addr,
  output logic             irq_ack,
  output logic             irq_busy,
  output logic [15:0]      pc_load,
  output logic             pc_load_vld,
  output logic [7:0]       flags_load,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  wire       acc    = psel && penable && clk_en;
  wire       wr_acc = acc && pwrite;
  wire [9:0] idx10  = paddr[11:2];
  wire       hit_mode = idx10 == {2'h0, svis_pkg::MODE_IDX};
  wire       hit_pcon = idx10 == {2'h0, svis_pkg::PORT_CTL_IDX};
  wire       hit_ppnd = idx10 == {2'h0, svis_pkg::PORT_PND_IDX};
  wire       hit_t0   = idx10 == {2'h0, svis_pkg::TMR_CTL_IDX};
  wire       hit_pwm  = idx10 == {2'h0, svis_pkg::PWM_CTL_IDX};
  wire       hit_st   = idx10 == {2'h0, svis_pkg::IRQ_STAT_IDX};
  wire       hit_clr  = idx10 == {2'h0, svis_pkg::IRQ_CLR_IDX};
  wire       hit_en   = idx10 == {2'h0, svis_pkg::IRQ_EN_IDX};
  wire       hit_ctl  = idx10 == {2'h0, svis_pkg::SEQ_CTL_IDX};
  wire       hit_sst  = idx10 == {2'h0, svis_pkg::SEQ_STAT_IDX};
  wire       hit_sp   = idx10 == {2'h0, svis_pkg::SEQ_SP_IDX};
  wire       hit_pc   = idx10 == {2'h0, svis_pkg::SEQ_PC_IDX};
  wire       mapped   = hit_mode | hit_pcon | hit_ppnd | hit_t0 | hit_pwm |
                        hit_st | hit_clr | hit_en | hit_ctl | hit_sst |
                        hit_sp | hit_pc;
  wire [7:0] wb = pwdata[7:0];

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  mode_q, pcon_q, tmr_ctl_q, pwm_ctl_q;
  logic [3:0]  pend_q;
  logic [2:0]  ev_q, ev_en_q;
  logic [15:0] sp_q, vec_q;
  logic [1:0]  pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
  svis_pkg::svis_state_type st_q, st_d;
  logic [15:0] pc_save_q;
  logic [7:0]  fl_save_q;

  svis_mem_if mbus ();

  svis_stack_mem u_mem (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .vec_addr (handler_addr),
    .mem      (mbus.mem)
  );

  // Core strobes written through the control register
  wire ctl_wr  = wr_acc && hit_ctl;
  wire eoi     = ctl_wr && wb[svis_pkg::CTL_EOI_BIT];
  wire ion_cmd  = ctl_wr && wb[svis_pkg::CTL_ION_BIT];
  wire ioff_cmd = ctl_wr && wb[svis_pkg::CTL_IOFF_BIT];
  wire ret_cmd = ctl_wr && wb[svis_pkg::CTL_RET_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Source enables and pending, one flat vector
  wire [3:0] src_en = {pcon_q[svis_pkg::P01_IE_BIT],
                       pcon_q[svis_pkg::P00_IE_BIT],
                       tmr_ctl_q[svis_pkg::T0_IE_BIT],
                       pwm_ctl_q[svis_pkg::PWM_IE_BIT]};
  // Pin edges judged only on agreeing second and third stages
  wire [1:0] pin_rise = pin_s2_q & pin_s3_q & ~pin_lvl_q;
  wire [3:0] src_evt  = {pin_rise[1], pin_rise[0], t0_match, pwm_ovf};
  wire [3:0] pend_clr;
  assign pend_clr[svis_pkg::SRC_PWM] = wr_acc && hit_pwm &&
                                       !wb[svis_pkg::PWM_PND_BIT];
  assign pend_clr[svis_pkg::SRC_T0]  = wr_acc && hit_t0 &&
                                       !wb[svis_pkg::T0_PND_BIT];
  assign pend_clr[svis_pkg::SRC_P00] = wr_acc && hit_ppnd && !wb[0];
  assign pend_clr[svis_pkg::SRC_P01] = wr_acc && hit_ppnd && !wb[1];

  // Pending bits: event wins over a clear in the same cycle
  genvar s;
  generate
    for (s = 0; s < svis_pkg::NSRC; s++) begin : g_pend
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          pend_q[s] <= 1'b0;
        else if (clk_en)
          pend_q[s] <= src_evt[s] | (pend_q[s] & ~pend_clr[s]);
      end
    end
  endgenerate

  // Any enabled pending source; no ranking among them
  wire any_req = |(pend_q & src_en);
  wire gie     = mode_q[svis_pkg::GIE_BIT];
  wire accept  = eoi && gie && any_req &&
                 (st_q == svis_pkg::ST_IDLE);

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q  <= 2'h0;
      pin_s2_q  <= 2'h0;
      pin_s3_q  <= 2'h0;
      pin_lvl_q <= 2'h0;
    end else if (clk_en) begin
      pin_s1_q  <= port_pin;
      pin_s2_q  <= pin_s1_q;
      pin_s3_q  <= pin_s2_q;
      pin_lvl_q <= (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q | pin_s3_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Peripheral control registers (port, timer0, pwm); system mode register below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcon_q    <= svis_pkg::REG_RST;
      tmr_ctl_q <= svis_pkg::REG_RST;
      pwm_ctl_q <= svis_pkg::REG_RST;
    end else if (wr_acc) begin
      if (hit_pcon) pcon_q <= wb;
      if (hit_t0)   tmr_ctl_q <= wb;
      if (hit_pwm)  pwm_ctl_q <= wb;
    end
  end

  // Global enable: entry clears, return and enable set, reset leaves zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mode_q <= svis_pkg::MODE_RST;
    else if (clk_en) begin
      if (accept)
        mode_q[svis_pkg::GIE_BIT] <= 1'b0;
      else if (st_q == svis_pkg::ST_POP_L)
        mode_q[svis_pkg::GIE_BIT] <= 1'b1;
      else if (ion_cmd)
        mode_q[svis_pkg::GIE_BIT] <= 1'b1;
      else if (ioff_cmd)
        mode_q[svis_pkg::GIE_BIT] <= 1'b0;
      else if (wr_acc && hit_mode)
        mode_q <= {4'h0, wb[3:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Entry and return sequence
  always_comb begin
    st_d = st_q;
    case (st_q)
      svis_pkg::ST_IDLE:   begin
        if (accept)       st_d = svis_pkg::ST_PUSH_L;
        else if (ret_cmd) st_d = svis_pkg::ST_POP_F;
      end
      svis_pkg::ST_PUSH_L: st_d = svis_pkg::ST_PUSH_H;
      svis_pkg::ST_PUSH_H: st_d = svis_pkg::ST_PUSH_F;
      svis_pkg::ST_PUSH_F: st_d = svis_pkg::ST_VEC_H;
      svis_pkg::ST_VEC_H:  st_d = svis_pkg::ST_VEC_L;
      svis_pkg::ST_VEC_L:  st_d = svis_pkg::ST_IDLE;
      svis_pkg::ST_POP_F:  st_d = svis_pkg::ST_POP_H;
      svis_pkg::ST_POP_H:  st_d = svis_pkg::ST_POP_L;
      svis_pkg::ST_POP_L:  st_d = svis_pkg::ST_IDLE;
      default:             st_d = svis_pkg::ST_IDLE;
    endcase
  end

  // Stack memory traffic per state
  wire push = st_q == svis_pkg::ST_PUSH_L || st_q == svis_pkg::ST_PUSH_H ||
              st_q == svis_pkg::ST_PUSH_F;
  wire pop  = st_q == svis_pkg::ST_POP_F || st_q == svis_pkg::ST_POP_H ||
              st_q == svis_pkg::ST_POP_L;
  assign mbus.wr    = push && clk_en;
  assign mbus.rd    = pop || st_q == svis_pkg::ST_VEC_H ||
                      st_q == svis_pkg::ST_VEC_L;
  assign mbus.wdata = (st_q == svis_pkg::ST_PUSH_L) ? pc_save_q[7:0] :
                      (st_q == svis_pkg::ST_PUSH_H) ? pc_save_q[15:8] :
                      fl_save_q;
  assign mbus.addr  = (st_q == svis_pkg::ST_VEC_H) ? svis_pkg::VEC_HI_ADDR :
                      (st_q == svis_pkg::ST_VEC_L) ? svis_pkg::VEC_LO_ADDR :
                      push ? sp_q : sp_q + 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q        <= svis_pkg::ST_IDLE;
      sp_q        <= svis_pkg::SP_RST;
      vec_q       <= svis_pkg::PC_RST;
      pc_save_q   <= 16'h0000;
      fl_save_q   <= 8'h00;
      irq_ack     <= 1'b0;
      pc_load     <= 16'h0000;
      pc_load_vld <= 1'b0;
      flags_load  <= 8'h00;
    end else if (clk_en) begin
      st_q        <= st_d;
      irq_ack     <= accept;
      pc_load_vld <= 1'b0;
      if (accept) begin
        pc_save_q <= pc_now;
        fl_save_q <= flags_now;
      end
      if (push) sp_q <= sp_q - 16'h0001;
      if (pop)  sp_q <= sp_q + 16'h0001;
      case (st_q)
        svis_pkg::ST_VEC_H: vec_q[15:8] <= mbus.rdata;
        svis_pkg::ST_VEC_L: begin
          vec_q[7:0]  <= mbus.rdata;
          pc_load     <= {vec_q[15:8], mbus.rdata};
          pc_load_vld <= 1'b1;
        end
        svis_pkg::ST_POP_F: flags_load <= mbus.rdata;
        svis_pkg::ST_POP_H: pc_load[15:8] <= mbus.rdata;
        svis_pkg::ST_POP_L: begin
          pc_load[7:0] <= mbus.rdata;
          pc_load_vld  <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  assign irq_busy = st_q != svis_pkg::ST_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // Sticky status, write-one clear, enable; set wins over clear
  wire [2:0] ev_set = {st_q == svis_pkg::ST_POP_L,
                       st_q == svis_pkg::ST_VEC_L, accept};
  wire [2:0] ev_clr = (wr_acc && hit_clr) ? wb[2:0] : 3'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_q    <= 3'h0;
      ev_en_q <= 3'h0;
    end else if (clk_en) begin
      ev_q <= ev_set | (ev_q & ~ev_clr);
      if (wr_acc && hit_en) ev_en_q <= wb[2:0];
    end
  end
  assign irq = |(ev_q & ev_en_q);

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [7:0] pnd_byte = {6'h00, pend_q[svis_pkg::SRC_P01],
                         pend_q[svis_pkg::SRC_P00]};
  wire [7:0] t0_rd  = {tmr_ctl_q[7:1], pend_q[svis_pkg::SRC_T0]};
  wire [7:0] pwm_rd = {pwm_ctl_q[7:3], pend_q[svis_pkg::SRC_PWM],
                       pwm_ctl_q[1:0]};
  wire [15:0] rd16 = hit_mode ? {8'h00, mode_q} :
                     hit_pcon ? {8'h00, pcon_q} :
                     hit_ppnd ? {8'h00, pnd_byte} :
                     hit_t0   ? {8'h00, t0_rd} :
                     hit_pwm  ? {8'h00, pwm_rd} :
                     hit_st   ? {13'h0000, ev_q} :
                     hit_en   ? {13'h0000, ev_en_q} :
                     hit_sst  ? {7'h00, st_q} :
                     hit_sp   ? sp_q :
                     hit_pc   ? vec_q : 16'h0000;
  assign prdata = {16'h0000, rd16};

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_entry_clears_gie;
    @(posedge pclk) disable iff (!presetn)
      (accept) |=> !mode_q[svis_pkg::GIE_BIT];
  endproperty
  a_entry_clears_gie: assert property (p_entry_clears_gie)
    else $error("global enable not cleared on entry");

  property p_accept_cond;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && !(eoi && gie && any_req)) |=> !irq_ack;
  endproperty
  a_accept_cond: assert property (p_accept_cond)
    else $error("request accepted without enables");

  property p_ack_pulse;
    @(posedge pclk) disable iff (!presetn)
      (accept && clk_en) |=> irq_ack ##1 (st_q == svis_pkg::ST_PUSH_H);
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge missing at entry");

  property p_push_order;
    @(posedge pclk) disable iff (!presetn)
      (st_q == svis_pkg::ST_PUSH_L && clk_en) |->
        mbus.wdata == pc_save_q[7:0];
  endproperty
  a_push_order: assert property (p_push_order)
    else $error("first pushed byte is not pc low");

  property p_vec_addr;
    @(posedge pclk) disable iff (!presetn)
      (st_q == svis_pkg::ST_VEC_H) |-> mbus.addr == 16'h0000;
  endproperty
  a_vec_addr: assert property (p_vec_addr)
    else $error("vector high byte not from zero");

  property p_ret_sets_gie;
    @(posedge pclk) disable iff (!presetn)
      (st_q == svis_pkg::ST_POP_L && clk_en) |=> gie;
  endproperty
  a_ret_sets_gie: assert property (p_ret_sets_gie)
    else $error("return did not set global enable");

  property p_pend_hold;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && pend_q[svis_pkg::SRC_T0] &&
       !pend_clr[svis_pkg::SRC_T0]) |=> pend_q[svis_pkg::SRC_T0];
  endproperty
  a_pend_hold: assert property (p_pend_hold)
    else $error("pending bit dropped without clear");

  property p_no_accept_busy;
    @(posedge pclk) disable iff (!presetn)
      (irq_busy && eoi) |=> !irq_ack;
  endproperty
  a_no_accept_busy: assert property (p_no_accept_busy)
    else $error("request accepted during sequence");

endmodule : svis_top
`default_nettype wire
